// file: verilog/wdtlc_pkg.sv
// watchdog timer with locked control: shared constants, types and layouts
// assumes a 25 MHz reference clock and an 8-bit APB byte address space
package wdtlc_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 25000000;
  localparam int unsigned REF_CLK_PERIOD_NS = 40;
  localparam int unsigned LF_CLK_HZ = 32768;
  localparam int unsigned ACC_W = 26;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'hC0;
  localparam logic [7:0] ADDR_INT_STATUS = 8'hC4;
  localparam logic [7:0] ADDR_INT_MASK = 8'hC8;
  localparam logic [7:0] CTRL_RESET = 8'h10;

  // ----------------------------------------------------------------
  // interrupt status and mask bits
  // ----------------------------------------------------------------
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_TIMEOUT_BIT = 0;
  localparam int unsigned INT_REJECT_BIT = 1;
  localparam logic [1:0] INT_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timeout selection
  // ----------------------------------------------------------------
  localparam logic [3:0] PRESCALE_IMMEDIATE = 4'h8;
  localparam logic [3:0] PRESCALE_MAX_TIMED = 4'h7;
  localparam logic [16:0] TIMEOUT_BASE_TICKS = 17'h00200;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] prescale;
    logic action_irq;
    logic flag;
    logic enable;
    logic unlock;
  } wdtlc_ctrl_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_COUNT = 2'b01,
    ST_FIRE = 2'b11
  } wdtlc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wdtlc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wdtlc_apb_rsp_t;

endpackage

// file: verilog/wdtlc_lf_tick.sv
// watchdog timer: low-frequency timebase tick generator
// assumes ref_clk faster than twice TICK_HZ; tick is one ref_clk cycle wide
`timescale 1ns/10ps
module wdtlc_lf_tick
#(
  parameter int unsigned TICK_HZ = wdtlc_pkg::LF_CLK_HZ
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // timebase
  output logic tick
);

  // ----------------------------------------------------------------
  // fractional accumulator
  // ----------------------------------------------------------------
  localparam logic [25:0] STEP = 26'(TICK_HZ);
  localparam logic [25:0] WRAP = 26'(wdtlc_pkg::REF_CLK_HZ);

  typedef struct packed {
    logic [25:0] acc;
    logic tick;
  } wdtlc_tick_state_t;

  wdtlc_tick_state_t st_ff;
  wdtlc_tick_state_t nxt_st;
  logic [25:0] sum;

  always_comb
  begin
    nxt_st = st_ff;
    sum = st_ff.acc + STEP;
    nxt_st.tick = 1'b0;
    if (sum >= WRAP)
    begin
      nxt_st.acc = sum - WRAP;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.acc = sum;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

// file: verilog/wdtlc_top.sv
// watchdog timer with locked control register, APB slave
// assumes synchronous APB inputs on ref_clk; reset is power-on only
//
// Function
// [RULE1] clearing enable stops supervision; no reset, no interrupt follows.
// [RULE2] while enabled, a missed refresh before timeout produces a timeout event.
// [RULE3] timeout is counted by a 16-bit counter on the 32.768 kHz tick.
// [RULE4] prescale 0..7 gives 2^N x 512 ticks; 8 resets at once; above reserved.
// [RULE5] control writes are taken only after an unlock step, every time.
// [RULE6] a timeout sets the status flag; a watchdog reset keeps it.
// [RULE7] a timeout gives system reset or interrupt by the action select bit.
// [RULE8] enable clears on a written zero and on a watchdog reset.
// [RULE9] the unlock must be the access right before the control write.
// [RULE10] each refresh restarts the counter from zero.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module wdtlc_top
#(
  parameter int unsigned LF_TICK_HZ = wdtlc_pkg::LF_CLK_HZ
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire wdtlc_pkg::wdtlc_apb_req_t apb_req,
  output wdtlc_pkg::wdtlc_apb_rsp_t apb_rsp,
  // system outputs
  output logic sys_reset_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wdtlc_pkg::wdtlc_apb_rsp_t rsp;
    wdtlc_pkg::wdtlc_ctrl_t ctrl;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    wdtlc_pkg::wdtlc_state_t state;
    logic [15:0] cnt;
    logic fire_reset;
    logic sys_reset;
    logic irq;
  } wdtlc_top_state_t;

  wdtlc_top_state_t st_ff;
  wdtlc_top_state_t nxt_st;

  logic lf_tick;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  wdtlc_lf_tick
  #(
    .TICK_HZ(LF_TICK_HZ)
  )
  u_lf_tick
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(lf_tick)
  );

  // ----------------------------------------------------------------
  // timeout limit
  // ----------------------------------------------------------------
  function automatic logic [15:0] limit_of(input logic [2:0] code);
    logic [16:0] ticks;
    ticks = wdtlc_pkg::TIMEOUT_BASE_TICKS << code;
    return 16'(ticks - 17'h00001);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic access;
  logic commit;
  logic is_ctrl;
  logic is_status;
  logic is_mask;
  logic refresh;
  logic reject_evt;
  logic timeout_evt;
  logic [1:0] set_bits;
  logic [1:0] clr_bits;
  wdtlc_pkg::wdtlc_ctrl_t wr_ctrl;

  always_comb
  begin
    nxt_st = st_ff;
    access = apb_req.psel & apb_req.penable;
    commit = access & st_ff.rsp.pready;
    is_ctrl = (apb_req.paddr == wdtlc_pkg::ADDR_CTRL);
    is_status = (apb_req.paddr == wdtlc_pkg::ADDR_INT_STATUS);
    is_mask = (apb_req.paddr == wdtlc_pkg::ADDR_INT_MASK);
    wr_ctrl = wdtlc_pkg::wdtlc_ctrl_t'(apb_req.pwdata[7:0]);
    refresh = 1'b0;
    reject_evt = 1'b0;
    timeout_evt = 1'b0;
    set_bits = 2'h0;
    clr_bits = 2'h0;
    nxt_st.sys_reset = 1'b0;

    // apb response: one wait state, answer registered
    nxt_st.rsp.pready = access & ~st_ff.rsp.pready;
    if (access & ~st_ff.rsp.pready)
    begin
      nxt_st.rsp.prdata = 32'h00000000;
      nxt_st.rsp.pslverr = 1'b0;
      if (is_ctrl)
      begin
        nxt_st.rsp.prdata[7:0] = st_ff.ctrl;
      end
      else if (is_status)
      begin
        nxt_st.rsp.prdata[1:0] = st_ff.int_status;
      end
      else if (is_mask)
      begin
        nxt_st.rsp.prdata[1:0] = st_ff.int_mask;
      end
      else
      begin
        nxt_st.rsp.pslverr = 1'b1;
      end
    end
    else if (commit)
    begin
      nxt_st.rsp.pslverr = 1'b0;
    end

    // register writes take effect at the completing edge
    if (commit)
    begin
      if (apb_req.pwrite & is_ctrl)
      begin
        if (st_ff.ctrl.unlock)
        begin
          nxt_st.ctrl.prescale = wr_ctrl.prescale; // [RULE5]
          nxt_st.ctrl.action_irq = wr_ctrl.action_irq;
          nxt_st.ctrl.enable = wr_ctrl.enable; // [RULE8]
          nxt_st.ctrl.flag = st_ff.ctrl.flag & wr_ctrl.flag;
          nxt_st.ctrl.unlock = 1'b0; // [RULE5]
          refresh = wr_ctrl.enable; // [RULE10]
        end
        else if (wr_ctrl.unlock)
        begin
          nxt_st.ctrl.unlock = 1'b1; // [RULE9]
        end
        else
        begin
          reject_evt = 1'b1; // [RULE5]
        end
      end
      else
      begin
        // any other access between unlock and write drops the unlock
        nxt_st.ctrl.unlock = 1'b0; // [RULE9]
        if (apb_req.pwrite & is_status)
        begin
          clr_bits = apb_req.pwdata[1:0];
        end
        if (apb_req.pwrite & is_mask)
        begin
          nxt_st.int_mask = apb_req.pwdata[1:0];
        end
      end
    end

    // supervision
    case (st_ff.state)
      wdtlc_pkg::ST_OFF:
      begin
        nxt_st.cnt = 16'h0000;
        if (nxt_st.ctrl.enable)
        begin
          nxt_st.state = wdtlc_pkg::ST_COUNT;
        end
      end
      wdtlc_pkg::ST_COUNT:
      begin
        if (~nxt_st.ctrl.enable)
        begin
          nxt_st.cnt = 16'h0000; // [RULE1]
          nxt_st.state = wdtlc_pkg::ST_OFF; // [RULE1]
        end
        else if (st_ff.ctrl.prescale == wdtlc_pkg::PRESCALE_IMMEDIATE)
        begin
          nxt_st.fire_reset = 1'b1; // [RULE4]
          nxt_st.state = wdtlc_pkg::ST_FIRE;
        end
        else if (refresh)
        begin
          nxt_st.cnt = 16'h0000; // [RULE10]
        end
        else if ((st_ff.ctrl.prescale <= wdtlc_pkg::PRESCALE_MAX_TIMED) & lf_tick)
        begin
          if (st_ff.cnt == limit_of(st_ff.ctrl.prescale[2:0])) // [RULE4]
          begin
            nxt_st.fire_reset = ~st_ff.ctrl.action_irq; // [RULE7]
            nxt_st.state = wdtlc_pkg::ST_FIRE; // [RULE2]
          end
          else
          begin
            nxt_st.cnt = st_ff.cnt + 16'h0001; // [RULE3]
          end
        end
      end
      wdtlc_pkg::ST_FIRE:
      begin
        nxt_st.cnt = 16'h0000;
        nxt_st.fire_reset = 1'b0;
        if (~nxt_st.ctrl.enable)
        begin
          nxt_st.state = wdtlc_pkg::ST_OFF; // [RULE1]
        end
        else if (st_ff.fire_reset)
        begin
          timeout_evt = 1'b1;
          nxt_st.sys_reset = 1'b1; // [RULE7]
          nxt_st.ctrl.enable = 1'b0; // [RULE8]
          nxt_st.state = wdtlc_pkg::ST_OFF;
        end
        else
        begin
          timeout_evt = 1'b1;
          set_bits[wdtlc_pkg::INT_TIMEOUT_BIT] = 1'b1; // [RULE7]
          nxt_st.state = wdtlc_pkg::ST_COUNT;
        end
      end
      default:
      begin
        nxt_st.cnt = 16'h0000;
        nxt_st.fire_reset = 1'b0;
        nxt_st.state = wdtlc_pkg::ST_OFF;
      end
    endcase

    // flag set wins over a written zero
    if (timeout_evt)
    begin
      nxt_st.ctrl.flag = 1'b1; // [RULE6]
    end

    // sticky interrupt status, set wins over clear
    set_bits[wdtlc_pkg::INT_REJECT_BIT] = reject_evt;
    nxt_st.int_status = (st_ff.int_status & ~clr_bits) | set_bits;
    nxt_st.irq = |(nxt_st.int_status & nxt_st.int_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff.rsp <= '0;
      st_ff.ctrl <= wdtlc_pkg::wdtlc_ctrl_t'(wdtlc_pkg::CTRL_RESET);
      st_ff.int_status <= wdtlc_pkg::INT_RESET;
      st_ff.int_mask <= wdtlc_pkg::INT_RESET;
      st_ff.state <= wdtlc_pkg::ST_OFF;
      st_ff.cnt <= 16'h0000;
      st_ff.fire_reset <= 1'b0;
      st_ff.sys_reset <= 1'b0;
      st_ff.irq <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp = st_ff.rsp;
  assign sys_reset_req = st_ff.sys_reset;
  assign irq = st_ff.irq;

endmodule

// file: dv/wdtlc_checker.sv
// watchdog checker: bus timing and output assertions
// assumes binding onto wdtlc_top
`timescale 1ns/10ps
module wdtlc_checker
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus and outputs
  input wire wdtlc_pkg::wdtlc_apb_req_t apb_req,
  input wire wdtlc_pkg::wdtlc_apb_rsp_t apb_rsp,
  input wire logic sys_reset_req,
  input wire logic irq
);
  logic wr_ff;
  logic nxt_wr;
  logic fin;
  logic rdc;
  logic mapped;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign fin = apb_rsp.pready;
  assign rdc = fin & ~apb_req.pwrite;
  assign mapped = apb_req.paddr inside {8'hC0, 8'hC4, 8'hC8};
  assign nxt_wr = wr_ff | (fin & apb_req.pwrite & (apb_req.paddr == 8'hC0));
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      wr_ff <= 1'b0;
    else
      wr_ff <= nxt_wr;
  end
  // ----
  // assertions
  // ----
  a_ready_wait: assert property (apb_req.psel && !apb_req.penable |-> ##2 fin)
    else $error("pready late");
  a_ready_once: assert property (fin |=> !fin)
    else $error("pready held");
  a_ready_access: assert property (fin |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  a_map_err: assert property (fin |-> apb_rsp.pslverr == !mapped)
    else $error("pslverr wrong");
  a_ctrl_pad: assert property (
    rdc && apb_req.paddr == 8'hC0 |-> apb_rsp.prdata[31:8] == 0)
    else $error("control upper bits");
  a_status_pad: assert property (
    rdc && apb_req.paddr == 8'hC4 |-> apb_rsp.prdata[31:2] == 0)
    else $error("status upper bits");
  a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset pulse long");
  a_idle_quiet: assert property (!wr_ff |-> !sys_reset_req && !irq)
    else $error("action while disabled");
  a_one_action: assert property (!(sys_reset_req && $rose(irq)))
    else $error("both actions");
  c_rst: cover property (sys_reset_req);
  c_irq: cover property ($rose(irq));
  c_err: cover property (fin && apb_rsp.pslverr);
endmodule
bind wdtlc_top wdtlc_checker i_chk (.ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .sys_reset_req(sys_reset_req), .irq(irq));

// file: dv/wdtlc_tb.sv
// watchdog testbench: apb master tasks and scenarios
// assumes wdtlc_top with a tick every 4 cycles
`timescale 1ns/10ps
module testbench;
  localparam int TK = 25000000 / 6250000;
  localparam logic [7:0] AC = wdtlc_pkg::ADDR_CTRL;
  localparam logic [7:0] AS = wdtlc_pkg::ADDR_INT_STATUS;
  localparam logic [7:0] AM = wdtlc_pkg::ADDR_INT_MASK;
  logic ref_clk;
  logic reset;
  wdtlc_pkg::wdtlc_apb_req_t req;
  wdtlc_pkg::wdtlc_apb_rsp_t rsp;
  logic sys_reset_req;
  logic irq;
  logic [31:0] rd;
  logic er;
  int at;
  int num_errors;
  int n_tests;
  wdtlc_top #(.LF_TICK_HZ(6250000)) i_dut (.ref_clk(ref_clk), .reset(reset), .apb_req(req),
    .apb_rsp(rsp), .sys_reset_req(sys_reset_req), .irq(irq));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----
  // tasks
  // ----
  task test_done;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (rsp.pready !== 1'b1 && i < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (i >= 20)
    begin
      num_errors++;
      test_done();
    end
  endtask
  task ctl(input logic [7:0] d);
    apb(1'b1, AC, 32'h1);
    apb(1'b1, AC, {24'h0, d});
  endtask
  task watch(input logic s, input int n);
    at = -1;
    for (int k = 0; k < n && at < 0; k++)
    begin
      @(posedge ref_clk);
      #1;
      if ((s ? irq : sys_reset_req) === 1'b1)
        at = k;
    end
  endtask
  task t_lock;
    apb(1'b0, AC, 0);
    chk(rd, 32'h10); // reset value
    apb(1'b1, AC, 32'h2);
    apb(1'b0, AC, 0);
    chk(rd, 32'h10); // unarmed write dropped
    apb(1'b0, AS, 0);
    chk(rd, 32'h2); // reject seen
    apb(1'b1, AM, 32'h2);
    watch(1'b1, 3);
    chk(at >= 0, 1); // reject interrupt unmasked
    apb(1'b1, AC, 32'h1);
    apb(1'b1, AM, 32'h0);
    apb(1'b1, AC, 32'h2);
    apb(1'b0, AC, 0);
    chk(rd, 32'h10); // gap disarms
    apb(1'b1, AS, 32'h2);
    apb(1'b0, AS, 0);
    chk(rd, 32'h0); // cleared
    apb(1'b0, 8'hD0, 0);
    chk({er, rd}, 33'h100000000); // unmapped
    $display("lock test done");
  endtask
  task t_irq;
    apb(1'b1, AM, 32'h1);
    ctl(8'h0A);
    watch(1'b1, 1500);
    chk(at, -1); // early
    ctl(8'h0A);
    watch(1'b1, 1800);
    chk(at, -1); // restart
    watch(1'b1, 400);
    chk(at > 236 && at < 262, 1); // timeout
    apb(1'b0, AC, 0);
    chk(rd, 32'hE); // flag, still on
    apb(1'b0, AS, 0);
    chk(rd, 32'h1); // status
    apb(1'b1, AS, 32'h1);
    apb(1'b0, AS, 0);
    chk({rd[0], irq}, 0); // cleared
    ctl(8'h08);
    watch(1'b1, 2500);
    chk(at, -1); // off
    apb(1'b0, AC, 0);
    chk(rd, 32'h8); // enable zero
    $display("irq test done");
  endtask
  task t_rst;
    int e;
    for (int p = 0; p < 2; p++)
    begin
      e = (512 * TK) << p;
      ctl({p[3:0], 4'h2});
      watch(1'b0, e + 20);
      chk(at >= e - 8 && at <= e + 8, 1); // period
      apb(1'b0, AC, 0);
      chk(rd, {p[3:0], 4'h4}); // enable cleared
    end
    ctl(8'h82);
    watch(1'b0, 20);
    chk(at >= 0, 1); // immediate
    ctl(8'h92);
    watch(1'b0, 3000);
    chk(at, -1); // reserved
    ctl(8'h00);
    $display("reset test done");
  endtask
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    req = '0;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_lock();
    t_irq();
    t_rst();
    test_done();
  end
endmodule
